//--- sar_adc_pkg.sv
// Shared constants for the successive approximation converter control
package sar_adc_pkg;
   localparam int          RESULT_WIDTH    = 8;
   localparam int          CLK_PERIOD_NS   = 20;
   localparam int          CONV_MAX_US     = 60;
   localparam int          CONV_MAX_CYC    = (CONV_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int          SAR_PERIOD_CYC  = 100;
   localparam int          HALF_PERIOD_CYC = SAR_PERIOD_CYC / 2;
   localparam logic [7:0]  RESULT_RST      = 8'h00;
   localparam logic [7:0]  CODE_ZERO       = 8'h00;
   localparam logic [7:0]  CODE_FULL       = 8'hFF;
   localparam int          CODE_COUNT      = 256;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_ARMED  = 4'b0010,
      ST_SAMPLE = 4'b0100,
      ST_CONV   = 4'b1000
   } seq_state_t;
endpackage

//--- sar_adc_host_interface.sv
// Host bus and conversion sequencer of an 8-bit SAR converter
//
// Behaviour
// - Selected write strobe falling edge clears done flag high, arms a cycle except in the sampling half period, where the sequencer ignores it.
// - Conversion begins on the next rising edge of the write strobe after arming; chip select is not checked at that edge.
// - After at most 60 us, result latched and done flag driven low on the same clock edge.
// - Done flag stays low while a completed result remains unread, unless a selected write strobe falls.
// - Selected read drives latched byte onto bus and returns flag high.
// - Input span maps onto 256 codes, one step is reference over 256.
// - Positive input sampled first, negative half an internal period later.
// - Comparator decision taken at end of each internal clock period.
// - Positive input equal to negative input gives the all-zero code.
// - Full scale saturates at the all-ones code.
// - Negative input at or above positive input yields the all-zero code.
// - Bus released after read strobe rises; driven only in selected reads.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_host_interface #(
   parameter int WIDTH   = sar_adc_pkg::RESULT_WIDTH,
   parameter int PERIOD  = sar_adc_pkg::SAR_PERIOD_CYC
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             chip_select_n,
   input  wire logic             write_strobe_n,
   input  wire logic             read_strobe_n,
   input  wire logic [WIDTH-1:0] positive_analog_input,
   input  wire logic [WIDTH-1:0] negative_analog_input,
   input  wire logic [WIDTH-1:0] reference_input,
   output logic      [WIDTH-1:0] result_bus,
   output logic                  result_bus_oe_n,
   output logic                  conversion_done_flag_n,
   output logic                  converting
);
   localparam int HALF = PERIOD / 2;

   sar_adc_pkg::seq_state_t state_r;
   logic             wr_n_d_r;
   logic             rd_sel_d_r;
   logic [15:0]      tick_r;
   logic [3:0]       bit_idx_r;
   logic [WIDTH-1:0] sar_r;
   logic [WIDTH-1:0] pos_s_r;
   logic [WIDTH-1:0] neg_s_r;
   logic [WIDTH-1:0] result_r;
   logic             done_n_r;

   wire wr_sel  = ~chip_select_n;
   wire wr_fall = wr_sel & ~write_strobe_n & wr_n_d_r;
   wire wr_rise = write_strobe_n & ~wr_n_d_r;
   wire rd_sel  = ~chip_select_n & ~read_strobe_n;
   wire period_end = (tick_r == 16'(PERIOD - 1));

   // span over 256 codes
   // Comparator model: trial code scaled by reference against differential
   function automatic logic trial_ok(input logic [WIDTH-1:0] trial,
                                     input logic [WIDTH-1:0] pos,
                                     input logic [WIDTH-1:0] neg,
                                     input logic [WIDTH-1:0] vref);
      logic [2*WIDTH+1:0] lhs;
      logic [2*WIDTH+1:0] rhs;
      lhs = '0;
      rhs = '0;
      // Negative at or above positive never passes any trial
      if (pos <= neg) begin
         trial_ok = 1'b0;
      end else begin
         lhs = (2*WIDTH+2)'(pos - neg) * (2*WIDTH+2)'(1 << WIDTH);
         rhs = (2*WIDTH+2)'(trial) * (2*WIDTH+2)'(vref);
         trial_ok = (lhs >= rhs);
      end
   endfunction

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_n_d_r   <= 1'b1;
         rd_sel_d_r <= 1'b0;
      end else begin
         wr_n_d_r   <= write_strobe_n;
         rd_sel_d_r <= rd_sel;
      end
   end

   // Sequencer
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r   <= sar_adc_pkg::ST_IDLE;
         tick_r    <= '0;
         bit_idx_r <= '0;
         sar_r     <= '0;
         pos_s_r   <= '0;
         neg_s_r   <= '0;
      end else begin
         case (state_r)
            sar_adc_pkg::ST_IDLE, sar_adc_pkg::ST_CONV: begin
               if (wr_fall) begin
                  state_r <= sar_adc_pkg::ST_ARMED;
               end else if (state_r == sar_adc_pkg::ST_CONV) begin
                  tick_r <= period_end ? '0 : tick_r + 16'd1;
                  if (period_end) begin
                     if (!trial_ok(sar_r, pos_s_r, neg_s_r, reference_input))
                        sar_r[bit_idx_r[2:0]] <= 1'b0;
                     if (bit_idx_r != 4'd0) begin
                        sar_r[bit_idx_r[2:0] - 3'd1] <= 1'b1;
                        bit_idx_r <= bit_idx_r - 4'd1;
                     end else begin
                        state_r <= sar_adc_pkg::ST_IDLE;
                     end
                  end
               end
            end
            sar_adc_pkg::ST_ARMED: begin
               if (wr_rise) begin
                  state_r <= sar_adc_pkg::ST_SAMPLE;
                  tick_r  <= '0;
                  pos_s_r <= positive_analog_input;
               end
            end
            sar_adc_pkg::ST_SAMPLE: begin
               tick_r <= tick_r + 16'd1;
               if (tick_r == 16'(HALF - 1)) begin
                  neg_s_r   <= negative_analog_input;
                  state_r   <= sar_adc_pkg::ST_CONV;
                  tick_r    <= '0;
                  bit_idx_r <= 4'(WIDTH - 1);
                  sar_r     <= WIDTH'(1) << (WIDTH - 1);
               end
            end
            default: state_r <= sar_adc_pkg::ST_IDLE;
         endcase
      end
   end

   wire conv_last = (state_r == sar_adc_pkg::ST_CONV) && period_end &&
                    (bit_idx_r == 4'd0) && !wr_fall;
   wire last_ok = trial_ok(sar_r, pos_s_r, neg_s_r, reference_input);

   always_ff @(posedge ref_clk) begin
      if (rst)
         result_r <= sarc_rst();
      else if (conv_last)
         result_r <= last_ok ? sar_r : {sar_r[WIDTH-1:1], 1'b0};
   end

   function automatic logic [WIDTH-1:0] sarc_rst();
      sarc_rst = WIDTH'(sar_adc_pkg::RESULT_RST);
   endfunction

   // flag low on the same edge as the latch, held until read or write fall
   always_ff @(posedge ref_clk) begin
      if (rst)
         done_n_r <= 1'b1;
      else if (conv_last)
         done_n_r <= 1'b0;
      // clear on write fall or read
      else if (wr_fall || rd_sel)
         done_n_r <= 1'b1;
   end

   // bus drive only in selected read
   always_ff @(posedge ref_clk) begin
      if (rst)
         result_bus <= '0;
      else if (rd_sel)
         result_bus <= result_r;
   end

   assign result_bus_oe_n        = ~(rd_sel && rd_sel_d_r);
   assign conversion_done_flag_n = done_n_r;
   assign converting = (state_r == sar_adc_pkg::ST_SAMPLE) ||
                       (state_r == sar_adc_pkg::ST_CONV);
endmodule

`default_nettype wire

//--- host_bus_model.sv
// Host processor side: select, write and read strobes
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
   input  wire logic       ref_clk,
   input  wire logic       oe_n,
   input  wire logic [7:0] bus,
   output logic            cs_n,
   output logic            wr_n,
   output logic            rd_n
);
   initial begin
      cs_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
   end
   task automatic start();
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      wr_n <= 1'b1;
      @(posedge ref_clk);
      cs_n <= 1'b1;
   endtask
   task automatic read(output logic [7:0] d, output logic oe);
      repeat (31) @(posedge ref_clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      d = bus;
      oe = oe_n;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

//--- sar_adc_host_interface_monitor.sv
// Checker for host bus timing of the converter
`timescale 1ns/1ps
`default_nettype none
module sar_adc_host_interface_monitor (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       chip_select_n,
   input wire logic       write_strobe_n,
   input wire logic       read_strobe_n,
   input wire logic [7:0] result_bus,
   input wire logic       result_bus_oe_n,
   input wire logic       conversion_done_flag_n,
   input wire logic       converting
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire rd = !chip_select_n && !read_strobe_n;
   AST_WR_FALL: assert property (!chip_select_n && $fell(write_strobe_n) |=>
      conversion_done_flag_n) else $error("flag not cleared by write");
   AST_START: assert property (!chip_select_n && $rose(write_strobe_n) |->
      ##[0:1] converting) else $error("no start on write rise");
   AST_BOUND: assert property ($rose(converting) |-> ##[1:900] !converting)
      else $error("conversion too long");
   AST_LATCH: assert property ($fell(conversion_done_flag_n) |-> !converting)
      else $error("flag before end");
   AST_HOLD: assert property (!conversion_done_flag_n && (chip_select_n ||
      (read_strobe_n && write_strobe_n)) |=> !conversion_done_flag_n)
      else $error("flag dropped unread");
   AST_RD_CLR: assert property (rd |=> conversion_done_flag_n)
      else $error("flag not cleared by read");
   AST_OE_ON: assert property (rd [*2] |-> !result_bus_oe_n)
      else $error("bus not driven");
   AST_OE_OFF: assert property (!result_bus_oe_n |-> rd)
      else $error("bus driven outside read");
   AST_STEADY: assert property (!result_bus_oe_n && $past(!result_bus_oe_n)
      |-> $stable(result_bus)) else $error("bus changed in read");
   cover property ($rose(converting));
   cover property ($fell(conversion_done_flag_n));
   cover property (!result_bus_oe_n);
endmodule
bind sar_adc_host_interface sar_adc_host_interface_monitor mon_u (
   .ref_clk(ref_clk), .rst(rst), .chip_select_n(chip_select_n),
   .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
   .result_bus(result_bus), .result_bus_oe_n(result_bus_oe_n),
   .conversion_done_flag_n(conversion_done_flag_n), .converting(converting));
`default_nettype wire

//--- sar_adc_host_interface_bench.sv
// Self-checking bench for the converter host interface
`timescale 1ns/1ps
`default_nettype none
module sar_adc_host_interface_bench;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] pos = 8'h00, neg = 8'h00, vref = 8'hFF, bus;
   logic       cs_n, wr_n, rd_n, oe_n, flag_n, conv;
   int         miscompares = 0;
   int         tests_run = 0;
   always #10 ref_clk = ~ref_clk;
   sar_adc_host_interface #(.PERIOD(4)) dut_u (.ref_clk(ref_clk),
      .rst(rst), .chip_select_n(cs_n), .write_strobe_n(wr_n),
      .read_strobe_n(rd_n), .positive_analog_input(pos),
      .negative_analog_input(neg), .reference_input(vref),
      .result_bus(bus), .result_bus_oe_n(oe_n),
      .conversion_done_flag_n(flag_n), .converting(conv));
   host_bus_model host_u (.ref_clk(ref_clk), .oe_n(oe_n), .bus(bus),
      .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n));
   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic run(string nm, logic [7:0] p, n, r, exp);
      logic [7:0] d;
      logic       oe;
      int         k;
      pos <= p;
      neg <= n;
      vref <= r;
      host_u.start();
      #1;
      check("flag_clr", {7'h00, flag_n}, 8'h01);
      check("busy", {7'h00, conv}, 8'h01);
      for (k = 0; k < 900 && flag_n; k++) @(posedge ref_clk);
      check("flag_set", {7'h00, flag_n}, 8'h00);
      host_u.read(d, oe);
      check("data", d, exp);
      check("oe_rd", {7'h00, oe}, 8'h00);
      check("flag_rd", {7'h00, flag_n}, 8'h01);
      check("oe_idle", {7'h00, oe_n}, 8'h01);
      $display("done %s", nm);
   endtask
   task automatic t_zero(); run("zero", 8'h40, 8'h40, 8'hFF, 8'h00); endtask
   task automatic t_neg(); run("neg", 8'h10, 8'h90, 8'hFF, 8'h00); endtask
   task automatic t_full(); run("full", 8'hFF, 8'h00, 8'hFF, 8'hFF); endtask
   task automatic t_top(); run("top", 8'hFE, 8'h00, 8'hFF, 8'hFE); endtask
   task automatic t_span(); run("span", 8'h40, 8'h00, 8'h80, 8'h80); endtask
   task automatic t_abort();
      int k;
      host_u.start();
      repeat (5) @(posedge ref_clk);
      host_u.start();
      for (k = 0; k < 900 && flag_n; k++) @(posedge ref_clk);
      repeat (10) @(posedge ref_clk);
      check("flag_hold", {7'h00, flag_n}, 8'h00);
      run("abort", 8'h90, 8'h10, 8'hFF, 8'h80);
   endtask
   initial begin
      #200000;
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_zero();
      t_neg();
      t_full();
      t_top();
      t_span();
      t_abort();
      wrap_up();
   end
endmodule
`default_nettype wire
